// File: bench/arso_chk.sv
// concurrent checks on the reading output pins
`timescale 1ns/1ps
module arso_chk #(
  parameter int SLOW_CHAR_CYC  = 400,
  parameter int FAST_CHAR_CYC  = 100,
  parameter int SLOW_BIT_CYC   = 32,
  parameter int FAST_BIT_CYC   = 8,
  parameter int UPDATE_MIN_CYC = 50
) (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       srst,
  // pins in
  input wire logic       xmit_req_n,
  input wire logic       rate_select,
  input wire logic       conv_done,
  // outputs
  input wire logic       disp_update_reg,
  input wire logic [6:0] char_data_reg,
  input wire logic       char_strobe_n_reg,
  input wire logic       loop_txd,
  input wire logic       ttl_txd,
  input wire logic       xmit_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  int stb_lo;
  int txd_lo;
  int upd_gap;
  int n_stb;
  // run lengths counted here, too long for repetition operators
  always @(posedge core_clk) begin
    if (srst) begin
      stb_lo <= 0;
      txd_lo <= 0;
      upd_gap <= UPDATE_MIN_CYC;
      n_stb <= 0;
    end else begin
      stb_lo <= char_strobe_n_reg ? 0 : stb_lo + 1;
      txd_lo <= loop_txd ? 0 : txd_lo + 1;
      upd_gap <= disp_update_reg ? 1 : upd_gap + 1;
      n_stb <= !xmit_busy ? 0 : n_stb + int'($fell(char_strobe_n_reg));
    end
  end
  sequence s_req_idle;
    !xmit_req_n && !xmit_busy;
  endsequence
  sequence s_stb_end;
    $rose(char_strobe_n_reg);
  endsequence
  a_reset_idle: assert property (disable iff (1'b0)
    srst |=> char_strobe_n_reg && loop_txd && !xmit_busy) else $error("not idle after reset");
  a_serial_same: assert property (loop_txd == ttl_txd)
    else $error("serial outputs differ");
  a_strobe_hold: assert property (!char_strobe_n_reg |-> $stable(char_data_reg))
    else $error("character moved under strobe");
  a_strobe_busy: assert property ($fell(char_strobe_n_reg) |-> xmit_busy)
    else $error("strobe outside a burst");
  a_strobe_width: assert property (s_stb_end |->
    stb_lo == (rate_select ? FAST_CHAR_CYC / 4 : SLOW_CHAR_CYC / 4)) else $error("strobe width");
  a_bit_width: assert property ($rose(loop_txd) |->
    txd_lo % (rate_select ? FAST_BIT_CYC : SLOW_BIT_CYC) == 0) else $error("bit width");
  a_burst_chars: assert property ($fell(xmit_busy) |-> n_stb == 11 || n_stb == 0)
    else $error("burst strobe count");
  a_req_start: assert property (s_req_idle [*3] |-> ##[1:4] xmit_busy)
    else $error("request not taken");
  a_disp_cause: assert property (disp_update_reg |-> $past(conv_done))
    else $error("display changed without a reading");
  a_update_gap: assert property (disp_update_reg |-> upd_gap >= UPDATE_MIN_CYC)
    else $error("readings too close");
endmodule // arso_chk

bind arso_top arso_chk #(.SLOW_CHAR_CYC(SLOW_CHAR_CYC), .FAST_CHAR_CYC(FAST_CHAR_CYC),
  .SLOW_BIT_CYC(SLOW_BIT_CYC), .FAST_BIT_CYC(FAST_BIT_CYC), .UPDATE_MIN_CYC(UPDATE_MIN_CYC))
  chk_u (.core_clk, .srst, .xmit_req_n, .rate_select, .conv_done, .disp_update_reg,
  .char_data_reg, .char_strobe_n_reg, .loop_txd, .ttl_txd, .xmit_busy);

// File: bench/arso_printer_model.sv
// printer side: latches strobed characters and decodes the serial line
`timescale 1ns/1ps
module arso_printer_model #(
  parameter int SLOW_BIT_CYC = 32,
  parameter int FAST_BIT_CYC = 8
) (
  // clock
  input wire logic       core_clk,
  // link from the meter
  input wire logic [6:0] char_data,
  input wire logic       char_strobe_n,
  input wire logic       txd,
  input wire logic       rate_select
);
  logic [6:0] par_q[$];
  logic [6:0] ser_q[$];
  int         bad_frames = 0;
  logic       stb_d = 1'b1;
  // data is only trusted at the falling strobe
  always @(posedge core_clk) begin
    if (stb_d && !char_strobe_n) begin
      par_q.push_back(char_data);
    end
    stb_d <= char_strobe_n;
  end
  // start, 7 data lsb first, even parity, stop, sampled mid bit
  initial begin : rx
    int bw;
    logic [9:0] sh;
    forever begin
      @(negedge txd);
      bw = rate_select ? FAST_BIT_CYC : SLOW_BIT_CYC;
      repeat (bw / 2) @(posedge core_clk);
      sh[0] = txd;
      for (int i = 1; i < 10; i++) begin
        repeat (bw) @(posedge core_clk);
        sh[i] = txd;
      end
      if (sh[0] || !sh[9] || ^sh[8:1]) bad_frames++;
      else ser_q.push_back(sh[7:1]);
    end
  end
endmodule // arso_printer_model

// File: bench/arso_tb_top.sv
// self-checking bench for the reading output block
`timescale 1ns/1ps
module arso_tb_top;
  logic        core_clk, srst, xmit_req_n, serial_req_loop, rate_select, unit_fahrenheit;
  logic        serial_fitted, conv_done, conv_negative, conv_overrange;
  logic [15:0] conv_magnitude;
  wire  [15:0] disp_value;
  wire  [6:0]  char_data;
  wire         strobe_n, loop_txd, ttl_txd, busy;
  wire         conv_start, integ_active, disp_neg, disp_ovr, upd;
  logic [6:0]  exp_q[11];
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;

  arso_top #(.SLOW_CHAR_CYC(400), .FAST_CHAR_CYC(100), .SLOW_BIT_CYC(32), .FAST_BIT_CYC(8),
    .UPDATE_MIN_CYC(50), .CONV_PERIOD_CYC(200), .INTEG_CYC(50)) dut_u (
    .core_clk, .srst, .xmit_req_n, .serial_req_loop, .rate_select, .unit_fahrenheit,
    .serial_fitted, .conv_start_reg(conv_start), .integ_active_reg(integ_active), .conv_done,
    .conv_negative, .conv_overrange, .conv_magnitude, .disp_value_reg(disp_value),
    .disp_negative_reg(disp_neg), .disp_overrange_reg(disp_ovr), .disp_update_reg(upd),
    .char_data_reg(char_data),
    .char_strobe_n_reg(strobe_n), .loop_txd, .ttl_txd, .xmit_busy(busy));
  arso_printer_model #(.SLOW_BIT_CYC(32), .FAST_BIT_CYC(8)) prn_u (
    .core_clk, .char_data, .char_strobe_n(strobe_n), .txd(loop_txd), .rate_select);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // whole run needs well under this
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  // one converter result; take says whether the spacing rule lets it through
  task automatic pulse(input logic neg, ovr, take, input logic [15:0] mag);
    conv_negative = neg;
    conv_overrange = ovr;
    conv_magnitude = mag;
    conv_done = 1'b1;
    @(negedge core_clk);
    conv_done = 1'b0;
    check("update", upd, take);
    repeat (3) @(negedge core_clk);
    check("update end", upd, 1'b0);
  endtask

  // two whole conversion periods of 200 cycles
  task automatic conv_pace;
    int starts;
    int integ;
    starts = 0;
    integ = 0;
    repeat (400) begin
      @(negedge core_clk);
      starts += int'(conv_start);
      integ += int'(integ_active);
    end
    check("conv starts", 16'(starts), 16'h0002);
    check("integ cycles", 16'(integ), 16'h0064);
  endtask

  task automatic expect_burst(input logic neg, ovr, fahr, input int mag);
    int v;
    int w;
    v = (mag < 2000) ? mag : mag / 10;
    w = 1000;
    exp_q[0] = neg ? 7'h2d : 7'h2b;
    for (int i = 1; i <= 4; i++) begin
      exp_q[i] = ovr ? 7'h45 : 7'h30 + 7'((v / w) % 10);
      w = w / 10;
    end
    exp_q[5] = 7'h20;
    if (!ovr && mag < 2000) begin
      exp_q[4] = 7'h2e;
      exp_q[5] = 7'h30 + 7'(v % 10);
    end
    exp_q[6] = 7'h20;
    exp_q[7] = fahr ? 7'h46 : 7'h43;
    exp_q[8] = 7'h20;
    exp_q[9] = 7'h0d;
    exp_q[10] = 7'h0a;
  endtask

  // one burst, with a request and a loop edge thrown in mid-burst
  task automatic burst(input logic by_loop);
    int t;
    int cc;
    cc = rate_select ? 100 : 400;
    prn_u.par_q.delete();
    prn_u.ser_q.delete();
    if (by_loop) serial_req_loop = 1'b0;
    else xmit_req_n = 1'b0;
    t = 0;
    while (busy !== 1'b1 && t < 20) begin
      @(negedge core_clk);
      t++;
    end
    check("busy", busy, 1'b1);
    xmit_req_n = 1'b1;
    serial_req_loop = 1'b1;
    repeat (cc * 3) @(negedge core_clk);
    xmit_req_n = 1'b0;
    serial_req_loop = 1'b0;
    repeat (10) @(negedge core_clk);
    xmit_req_n = 1'b1;
    serial_req_loop = 1'b1;
    t = cc * 3 + 10;
    while (busy !== 1'b0 && t < cc * 13) begin
      @(negedge core_clk);
      t++;
    end
    check("burst length", 16'(t / cc), 16'h000b);
    repeat (20) @(negedge core_clk);
    check("extra burst", busy, 1'b0);
    check("strobed count", 16'(prn_u.par_q.size()), by_loop ? 16'h0000 : 16'h000b);
    check("serial count", 16'(prn_u.ser_q.size()), serial_fitted ? 16'h000b : 16'h0000);
    check("bad frames", 16'(prn_u.bad_frames), 16'h0000);
    for (int i = 0; i < 11; i++) begin
      if (i < prn_u.ser_q.size()) check("serial char", prn_u.ser_q[i], exp_q[i]);
      if (i < prn_u.par_q.size()) check("strobed char", prn_u.par_q[i], exp_q[i]);
    end
  endtask

  // serial option absent: loop request ignored, strobed burst only, line stays mark
  task automatic unfitted;
    serial_fitted = 1'b0;
    repeat (8) @(negedge core_clk);
    serial_req_loop = 1'b0;
    repeat (20) @(negedge core_clk);
    check("loop unfitted", busy, 1'b0);
    serial_req_loop = 1'b1;
    repeat (8) @(negedge core_clk);
    burst(1'b0);
    serial_fitted = 1'b1;
  endtask

  initial begin
    srst = 1'b1;
    xmit_req_n = 1'b1;
    serial_req_loop = 1'b1;
    rate_select = 1'b1;
    unit_fahrenheit = 1'b0;
    serial_fitted = 1'b1;
    conv_done = 1'b0;
    conv_negative = 1'b0;
    conv_overrange = 1'b0;
    conv_magnitude = 16'h0000;
    repeat (5) @(negedge core_clk);
    srst = 1'b0;
    repeat (8) @(negedge core_clk);
    check("idle strobe", strobe_n, 1'b1);
    check("idle line", loop_txd, 1'b1);
    pulse(1'b0, 1'b0, 1'b1, 16'h04d2);
    repeat (6) @(negedge core_clk);
    pulse(1'b0, 1'b0, 1'b0, 16'h0037);
    check("display", disp_value, 16'h04d2);
    conv_pace();
    pulse(1'b1, 1'b0, 1'b1, 16'h07cf);
    check("display sign", disp_neg, 1'b1);
    expect_burst(1'b1, 1'b0, 1'b0, 1999);
    burst(1'b0);
    check("display", disp_value, 16'h07cf);
    rate_select = 1'b0;
    unit_fahrenheit = 1'b1;
    pulse(1'b0, 1'b0, 1'b1, 16'h07d0);
    expect_burst(1'b0, 1'b0, 1'b1, 2000);
    burst(1'b0);
    rate_select = 1'b1;
    pulse(1'b1, 1'b1, 1'b1, 16'h0000);
    check("display over", disp_ovr, 1'b1);
    expect_burst(1'b1, 1'b1, 1'b1, 0);
    burst(1'b1);
    unfitted();
    test_done();
  end
endmodule // arso_tb_top

// File: include/arso_consts.vh
// constants for the ascii reading serial output block
`ifndef ARSO_CONSTS_VH
`define ARSO_CONSTS_VH

// core clock in kHz, keeps the cycle products inside 32 bits
`define ARSO_CLK_KHZ          100000
`define ARSO_CLK_HZ           (`ARSO_CLK_KHZ * 1000)

// character rates in characters per second
`define ARSO_SLOW_CHAR_PER_S  25
`define ARSO_FAST_CHAR_PER_S  100
// baud rates in bits per second
`define ARSO_SLOW_BAUD        300
`define ARSO_FAST_BAUD        1200
// least time between two new readings, in ms
`define ARSO_UPDATE_MIN_MS    150
// conversions per ten seconds (2.5 per second) and integration time in ms
`define ARSO_CONV_PER_10S     25
`define ARSO_INTEG_MS         100

// burst layout
`define ARSO_CHARS_PER_BURST  4'd11
`define ARSO_LAST_CHAR        4'd10
`define ARSO_POS_SIGN         4'd0
`define ARSO_POS_NUM1         4'd1
`define ARSO_POS_NUM2         4'd2
`define ARSO_POS_NUM3         4'd3
`define ARSO_POS_NUM4         4'd4
`define ARSO_POS_NUM5         4'd5
`define ARSO_POS_UNIT         4'd7
`define ARSO_POS_CR           4'd9
`define ARSO_POS_LF           4'd10

// reading format: magnitude in tenths of a degree
`define ARSO_AUTORANGE_LIMIT  16'd2000
`define ARSO_W4               16'd10000
`define ARSO_W3               16'd1000
`define ARSO_W2               16'd100
`define ARSO_W1               16'd10
`define ARSO_W0               16'd1
`define ARSO_TOP_DIGIT        3'd4

// ascii codes
`define ARSO_CH_PLUS          7'h2b
`define ARSO_CH_MINUS         7'h2d
`define ARSO_CH_DOT           7'h2e
`define ARSO_CH_SPACE         7'h20
`define ARSO_CH_ZERO          7'h30
`define ARSO_CH_E             7'h45
`define ARSO_CH_C             7'h43
`define ARSO_CH_F             7'h46
`define ARSO_CH_CR            7'h0d
`define ARSO_CH_LF            7'h0a

// serial frame: start, 7 data lsb first, even parity, stop
`define ARSO_FRAME_BITS       4'd10

// pin reset levels: fitted, unit, rate, loop, req_n
`define ARSO_PIN_RST          5'h07

`endif

// File: verilog/arso_fifo.v
// small character fifo with valid/ready on both sides
`timescale 1ns/1ps
module arso_fifo #(
  parameter WIDTH = 7,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             srst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];

  // pointers wrap on depth so a non power of two depth works too
  always @(posedge core_clk) begin
    if (srst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule // arso_fifo

// File: verilog/arso_top.v
// reading formatter with strobed character output and serial output
`timescale 1ns/1ps
`include "arso_consts.vh"
module arso_top #(
  parameter CNT_W = 26,
  parameter BIT_W = 19,
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2,
  parameter [CNT_W-1:0] SLOW_CHAR_CYC = `ARSO_CLK_HZ / `ARSO_SLOW_CHAR_PER_S,
  parameter [CNT_W-1:0] FAST_CHAR_CYC = `ARSO_CLK_HZ / `ARSO_FAST_CHAR_PER_S,
  parameter [BIT_W-1:0] SLOW_BIT_CYC = `ARSO_CLK_HZ / `ARSO_SLOW_BAUD,
  parameter [BIT_W-1:0] FAST_BIT_CYC = `ARSO_CLK_HZ / `ARSO_FAST_BAUD,
  parameter [CNT_W-1:0] UPDATE_MIN_CYC = `ARSO_CLK_KHZ * `ARSO_UPDATE_MIN_MS,
  parameter [CNT_W-1:0] CONV_PERIOD_CYC = `ARSO_CLK_KHZ * 10000 / `ARSO_CONV_PER_10S,
  parameter [CNT_W-1:0] INTEG_CYC = `ARSO_CLK_KHZ * `ARSO_INTEG_MS
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        srst,
  // pins from outside the clock domain
  input  wire        xmit_req_n,
  input  wire        serial_req_loop,
  input  wire        rate_select,
  input  wire        unit_fahrenheit,
  input  wire        serial_fitted,
  // converter side
  output reg         conv_start_reg,
  output reg         integ_active_reg,
  input  wire        conv_done,
  input  wire        conv_negative,
  input  wire        conv_overrange,
  input  wire [15:0] conv_magnitude,
  // display side
  output reg  [15:0] disp_value_reg,
  output reg         disp_negative_reg,
  output reg         disp_overrange_reg,
  output reg         disp_update_reg,
  // character output
  output reg  [6:0]  char_data_reg,
  output reg         char_strobe_n_reg,
  // serial outputs, high is mark
  output wire        loop_txd,
  output wire        ttl_txd,
  // status
  output wire        xmit_busy
);

  localparam G_IDLE  = 2'd0;
  localparam G_DIGIT = 2'd1;
  localparam G_EMIT  = 2'd2;
  localparam G_DRAIN = 2'd3;

  // pin synchronisers: three flops, a change counts once the last two agree
  wire [4:0] pin_raw = {serial_fitted, unit_fahrenheit, rate_select, serial_req_loop, xmit_req_n};
  wire [4:0] pin_filt;
  localparam [4:0] PIN_RST = `ARSO_PIN_RST;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_sync
      reg [2:0] sh_reg;
      reg       filt_reg;
      always @(posedge core_clk) begin
        if (srst) begin
          sh_reg   <= {3{PIN_RST[g]}};
          filt_reg <= PIN_RST[g];
        end else begin
          sh_reg <= {sh_reg[1:0], pin_raw[g]};
          if (sh_reg[1] == sh_reg[2])
            filt_reg <= sh_reg[2];
        end
      end
      assign pin_filt[g] = filt_reg;
    end
  endgenerate

  wire req_n_f   = pin_filt[0];
  wire loop_f    = pin_filt[1];
  wire rate_fast = pin_filt[2];
  wire unit_f    = pin_filt[3];
  wire fitted_f  = pin_filt[4];

  // conversion pacing and update spacing
  reg [CNT_W-1:0] conv_cnt_reg;
  reg [CNT_W-1:0] upd_cnt_reg;
  wire            upd_ok = (upd_cnt_reg >= UPDATE_MIN_CYC);

  always @(posedge core_clk) begin
    if (srst) begin
      conv_cnt_reg     <= {CNT_W{1'b0}};
      conv_start_reg   <= 1'b0;
      integ_active_reg <= 1'b0;
    end else begin
      conv_cnt_reg     <= (conv_cnt_reg == CONV_PERIOD_CYC - 1'b1) ? {CNT_W{1'b0}}
                                                                   : conv_cnt_reg + 1'b1;
      conv_start_reg   <= (conv_cnt_reg == {CNT_W{1'b0}});
      integ_active_reg <= (conv_cnt_reg < INTEG_CYC);
    end
  end

  // display latch has no path from the request logic
  always @(posedge core_clk) begin
    if (srst) begin
      upd_cnt_reg        <= UPDATE_MIN_CYC;
      disp_value_reg     <= 16'h0000;
      disp_negative_reg  <= 1'b0;
      disp_overrange_reg <= 1'b0;
      disp_update_reg    <= 1'b0;
    end else begin
      disp_update_reg <= 1'b0;
      if (conv_done && upd_ok) begin
        upd_cnt_reg        <= {CNT_W{1'b0}};
        disp_value_reg     <= conv_magnitude;
        disp_negative_reg  <= conv_negative;
        disp_overrange_reg <= conv_overrange;
        disp_update_reg    <= 1'b1;
      end else if (!upd_ok) begin
        upd_cnt_reg <= upd_cnt_reg + 1'b1;
      end
    end
  end

  // burst generator
  reg [1:0]  gen_state_reg;
  reg [15:0] rem_reg;
  reg [19:0] dig_reg;
  reg [2:0]  dig_idx_reg;
  reg [3:0]  ch_idx_reg;
  reg        snap_neg_reg;
  reg        snap_ovr_reg;
  reg        snap_tenths_reg;
  reg        serial_only_reg;
  reg        loop_prev_reg;
  reg [15:0] weight;
  reg [6:0]  burst_char;

  wire gen_idle  = (gen_state_reg == G_IDLE);
  wire loop_fall = loop_prev_reg && !loop_f;
  wire start_par = gen_idle && !req_n_f;
  wire start_ser = gen_idle && loop_fall && fitted_f;

  wire       fifo_in_valid = (gen_state_reg == G_EMIT);
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire       fifo_out_ready;
  wire [6:0] fifo_out_data;

  reg              seq_active_reg;
  reg [CNT_W-1:0]  seq_cnt_reg;
  wire             uart_busy;

  assign xmit_busy = !gen_idle;

  always @* begin
    case (dig_idx_reg)
      3'd4:    weight = `ARSO_W4;
      3'd3:    weight = `ARSO_W3;
      3'd2:    weight = `ARSO_W2;
      3'd1:    weight = `ARSO_W1;
      default: weight = `ARSO_W0;
    endcase
  end

  // character at the current burst position
  always @* begin
    case (ch_idx_reg)
      `ARSO_POS_SIGN: burst_char = snap_neg_reg ? `ARSO_CH_MINUS : `ARSO_CH_PLUS;
      `ARSO_POS_NUM1: burst_char = snap_ovr_reg ? `ARSO_CH_E :
                                   `ARSO_CH_ZERO + {3'b000, snap_tenths_reg ? dig_reg[15:12]
                                                                            : dig_reg[19:16]};
      `ARSO_POS_NUM2: burst_char = snap_ovr_reg ? `ARSO_CH_E :
                                   `ARSO_CH_ZERO + {3'b000, snap_tenths_reg ? dig_reg[11:8]
                                                                            : dig_reg[15:12]};
      `ARSO_POS_NUM3: burst_char = snap_ovr_reg ? `ARSO_CH_E :
                                   `ARSO_CH_ZERO + {3'b000, snap_tenths_reg ? dig_reg[7:4]
                                                                            : dig_reg[11:8]};
      `ARSO_POS_NUM4: burst_char = snap_ovr_reg ? `ARSO_CH_E :
                                   snap_tenths_reg ? `ARSO_CH_DOT
                                                   : `ARSO_CH_ZERO + {3'b000, dig_reg[7:4]};
      `ARSO_POS_NUM5: burst_char = (snap_tenths_reg && !snap_ovr_reg)
                                   ? `ARSO_CH_ZERO + {3'b000, dig_reg[3:0]} : `ARSO_CH_SPACE;
      `ARSO_POS_UNIT: burst_char = unit_f ? `ARSO_CH_F : `ARSO_CH_C;
      `ARSO_POS_CR:   burst_char = `ARSO_CH_CR;
      `ARSO_POS_LF:   burst_char = `ARSO_CH_LF;
      default:        burst_char = `ARSO_CH_SPACE;
    endcase
  end

  always @(posedge core_clk) begin
    if (srst) begin
      gen_state_reg   <= G_IDLE;
      rem_reg         <= 16'h0000;
      dig_reg         <= 20'h00000;
      dig_idx_reg     <= 3'd0;
      ch_idx_reg      <= 4'h0;
      snap_neg_reg    <= 1'b0;
      snap_ovr_reg    <= 1'b0;
      snap_tenths_reg <= 1'b0;
      serial_only_reg <= 1'b0;
      loop_prev_reg   <= 1'b1;
    end else begin
      // edge history runs during bursts too, so a busy-time edge is lost
      loop_prev_reg <= loop_f;
      case (gen_state_reg)
        G_IDLE: begin
          if (start_par || start_ser) begin
            // snapshot so a display update cannot tear a burst
            rem_reg         <= disp_value_reg;
            snap_neg_reg    <= disp_negative_reg;
            snap_ovr_reg    <= disp_overrange_reg;
            snap_tenths_reg <= (disp_value_reg < `ARSO_AUTORANGE_LIMIT);
            serial_only_reg <= !start_par;
            dig_reg         <= 20'h00000;
            dig_idx_reg     <= `ARSO_TOP_DIGIT;
            gen_state_reg   <= G_DIGIT;
          end
        end
        G_DIGIT: begin
          // repeated subtraction, slow but tiny and far inside a character time
          if (rem_reg >= weight) begin
            rem_reg <= rem_reg - weight;
            dig_reg[dig_idx_reg*4 +: 4] <= dig_reg[dig_idx_reg*4 +: 4] + 1'b1;
          end else if (dig_idx_reg == 3'd0) begin
            ch_idx_reg    <= 4'h0;
            gen_state_reg <= G_EMIT;
          end else begin
            dig_idx_reg <= dig_idx_reg - 1'b1;
          end
        end
        G_EMIT: begin
          if (fifo_in_ready) begin
            ch_idx_reg <= ch_idx_reg + 1'b1;
            if (ch_idx_reg == `ARSO_LAST_CHAR)
              gen_state_reg <= G_DRAIN;
          end
        end
        G_DRAIN: begin
          if (!fifo_out_valid && !seq_active_reg && !uart_busy)
            gen_state_reg <= G_IDLE;
        end
        default: gen_state_reg <= G_IDLE;
      endcase
    end
  end

  arso_fifo #(
    .WIDTH (7),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (burst_char),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // character sequencer: one character per character period
  wire [CNT_W-1:0] char_cyc  = rate_fast ? FAST_CHAR_CYC : SLOW_CHAR_CYC;
  wire [BIT_W-1:0] bit_cyc   = rate_fast ? FAST_BIT_CYC : SLOW_BIT_CYC;
  wire [CNT_W-1:0] fall_at   = char_cyc >> 1;
  wire [CNT_W-1:0] rise_at   = char_cyc - (char_cyc >> 2);
  wire             take_char = fifo_out_valid && !seq_active_reg;
  wire             uart_go   = take_char && fitted_f;

  assign fifo_out_ready = !seq_active_reg;

  always @(posedge core_clk) begin
    if (srst) begin
      seq_active_reg    <= 1'b0;
      seq_cnt_reg       <= {CNT_W{1'b0}};
      char_data_reg     <= 7'h00;
      char_strobe_n_reg <= 1'b1;
    end else if (take_char) begin
      // the take edge is cycle one, so a character period is exactly char_cyc
      seq_active_reg    <= 1'b1;
      seq_cnt_reg       <= {{(CNT_W-1){1'b0}}, 1'b1};
      char_data_reg     <= fifo_out_data;
      char_strobe_n_reg <= 1'b1;
    end else if (seq_active_reg) begin
      seq_cnt_reg <= seq_cnt_reg + 1'b1;
      // lines settle half a period before the falling edge
      if (seq_cnt_reg == fall_at && !serial_only_reg)
        char_strobe_n_reg <= 1'b0;
      else if (seq_cnt_reg == rise_at)
        char_strobe_n_reg <= 1'b1;
      if (seq_cnt_reg == char_cyc - 1'b1)
        seq_active_reg <= 1'b0;
    end
  end

  // a frame is shorter than a character period at both rates
  wire uart_txd;

  arso_uart_tx #(
    .BIT_W (BIT_W)
  ) u_uart (
    .core_clk   (core_clk),
    .srst       (srst),
    .start      (uart_go),
    .data       (fifo_out_data),
    .bit_cycles (bit_cyc),
    .txd_reg    (uart_txd),
    .busy       (uart_busy)
  );

  assign loop_txd = uart_txd;
  assign ttl_txd  = uart_txd;

endmodule // arso_top

// File: verilog/arso_uart_tx.v
// asynchronous serial transmitter for one 7-bit character
`timescale 1ns/1ps
`include "arso_consts.vh"
module arso_uart_tx #(
  parameter BIT_W = 19
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             srst,
  // character in
  input  wire             start,
  input  wire [6:0]       data,
  input  wire [BIT_W-1:0] bit_cycles,
  // line out, high is mark
  output reg              txd_reg,
  output wire             busy
);

  reg [9:0]       shift_reg;
  reg [3:0]       bits_left_reg;
  reg [BIT_W-1:0] cyc_reg;

  assign busy = (bits_left_reg != 4'h0);

  always @(posedge core_clk) begin
    if (srst) begin
      txd_reg       <= 1'b1;
      shift_reg     <= 10'h3ff;
      bits_left_reg <= 4'h0;
      cyc_reg       <= {BIT_W{1'b0}};
    end else if (start && !busy) begin
      // same frame for loop and ttl outputs
      txd_reg       <= 1'b0;
      shift_reg     <= {1'b1, ^data, data, 1'b0};
      bits_left_reg <= `ARSO_FRAME_BITS;
      cyc_reg       <= {BIT_W{1'b0}};
    end else if (busy) begin
      if (cyc_reg == bit_cycles - 1'b1) begin
        cyc_reg       <= {BIT_W{1'b0}};
        shift_reg     <= {1'b1, shift_reg[9:1]};
        txd_reg       <= shift_reg[1];
        bits_left_reg <= bits_left_reg - 1'b1;
      end else begin
        cyc_reg <= cyc_reg + 1'b1;
      end
    end else begin
      txd_reg <= 1'b1;
    end
  end

endmodule // arso_uart_tx
